// *** core/fspg_pkg.sv ***
/*
  fspg_pkg: constants and carrier types for the flash self-program guard.
  assumes: word addresses into program flash, lock and fuse bits are
  active low (0 = programmed), one core clock domain.
*/
package fspg_pkg;
  localparam int ADDR_W = 14;
  // register map of the guard's own control port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_LOCK = 4'h2;
  // ctrl register field positions
  localparam int CTRL_SPE = 0;
  localparam int CTRL_OP0 = 1;
  localparam int CTRL_OP1 = 2;
  localparam int CTRL_RWWCLR = 4;
  localparam int CTRL_IE = 7;
  // command codes written into the control register
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] CMD_MASK = 8'h7f;
  // window after the control write in which a store is accepted
  localparam int ARM_CYC = 4;
  // general lock modes (two-bit lock value, active low)
  localparam logic [1:0] LK_NONE = 2'h3;
  localparam logic [1:0] LK_WRITE = 2'h2;
  localparam logic [1:0] LK_RW = 2'h0;
  // boot lock pair reset value: unprogrammed
  localparam logic [3:0] BLB_RST = 4'hf;
  // default programming time in ns
  localparam int PROG_NS = 4000000;
  localparam int CLK_NS = 8;
  localparam int PROG_CYC = PROG_NS / CLK_NS;

  typedef struct packed {
    logic store; // store request strobe
    logic load; // load request strobe
    logic [ADDR_W-1:0] addr; // target word address
    logic from_boot; // core executes from boot section
  } fspg_req_t;

  typedef enum logic [1:0] {
    FSPG_IDLE = 2'b00,
    FSPG_RWW = 2'b01,
    FSPG_NO_READ_WHILE_WRITE_REGION = 2'b11
  } fspg_state_t;
endpackage

// *** core/fspg_guard.sv ***
/*
  fspg_guard: access checker and stall control for flash self-programming.
  assumes: the core presents one request per cycle as a packed struct and
  tells which section it is running from; fuses are stable after reset.
*/
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
// Notes on behaviour
// RL1: stores from application section are ignored
// RL2: only boot-section stores start programming, anywhere
// RL3: boot size fuses set the section boundary
// RL4: rww page programming lets no_read_while_write_region reads continue
// RL5: no_read_while_write_region page programming halts the core throughout
// RL6: rww region reads invalid while programming
// RL7: boot section always inside no_read_while_write_region region
// RL8: busy flag reads one while rww blocked
// RL9: software clears busy before reading rww
// RL10: software keeps vectors out of rww
// RL11: boot locks only programmable, erase restores
// RL12: write lock refuses all stores
// RL13: read/write lock refuses loads and stores
// RL14: application mode 1 has no restriction
// RL15: application modes 2,3 block stores there
// RL16: application modes 3,4 block boot loads there
// RL17: application modes 3,4 mask interrupts in app
// RL18: boot mode 1 has no restriction
// RL19: boot modes 2,3 block stores there
// RL20: boot modes 3,4 block app loads there
// RL21: boot modes 3,4 mask interrupts in boot
// RL22: store must follow command within four cycles
// RL23: interrupt held while self-program enable clear
// RL24: check by source and target section, drop silently
// RL25: busy set at rww programming, software clears
module fspg_guard #(
  parameter int PROG_CYCLES = fspg_pkg::PROG_CYC,
  parameter int NO_READ_WHILE_WRITE_REGION_START = 14'h3800
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire fspg_pkg::fspg_req_t REQ,
  input wire logic [1:0] BOOT_SIZE_FUSES,
  input wire logic [1:0] GEN_LOCK,
  input wire logic IVEC_IN_BOOT,
  input wire logic CHIP_ERASE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic CORE_HALT,
  output logic LOAD_GRANT,
  output logic LOAD_VALID,
  output logic PROG_START,
  output logic PROG_BUSY,
  output logic INT_BLOCK,
  output logic SPM_IRQ
);
  localparam int AW = fspg_pkg::ADDR_W;
  localparam int CW = $clog2(PROG_CYCLES + 1);

  fspg_pkg::fspg_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [7:0] ctrl_q;
  logic [2:0] arm_q;
  logic rww_busy_flag_q;
  logic [3:0] blb_q; // {boot_lock_hi, boot_lock_lo, app_lock_hi, app_lock_lo}
  logic [AW-1:0] boot_start;
  logic tgt_boot;
  logic tgt_rww;
  logic store_ok;
  logic load_ok;
  logic prog_cmd;
  logic app_pair_st;
  logic app_pair_ld;
  logic boot_pair_st;
  logic boot_pair_ld;

  // boot section start from fuses, top quarter at most
  function automatic logic [AW-1:0] boot_base(input logic [1:0] f);
    logic [AW-1:0] sz;
    sz = AW'(14'h0200) << (2'h3 - f);
    return AW'((AW+1)'(1) << AW) - sz;
  endfunction

  // boot start never below no_read_while_write_region start keeps boot inside no_read_while_write_region
  assign boot_start = boot_base(BOOT_SIZE_FUSES) < AW'(NO_READ_WHILE_WRITE_REGION_START) ?
    AW'(NO_READ_WHILE_WRITE_REGION_START) : boot_base(BOOT_SIZE_FUSES); // RL3 RL7
  assign tgt_boot = REQ.addr >= boot_start; // RL3
  assign tgt_rww = REQ.addr < AW'(NO_READ_WHILE_WRITE_REGION_START);

  // lock pair decode: store blocked in modes 2,3; load blocked in 3,4
  assign app_pair_st = ~blb_q[0]; // RL14 RL15
  assign app_pair_ld = ~blb_q[1]; // RL14 RL16
  assign boot_pair_st = ~blb_q[2]; // RL18 RL19
  assign boot_pair_ld = ~blb_q[3]; // RL18 RL20

  // erase and write start an operation, a page load does not
  function automatic logic cmd_starts_op(input logic [7:0] c);
    logic [7:0] code;
    code = c & fspg_pkg::CMD_MASK;
    return code == fspg_pkg::CMD_ERASE || code == fspg_pkg::CMD_WRITE;
  endfunction

  assign prog_cmd = cmd_starts_op(ctrl_q);

  // stores: boot source only, general lock, section lock, armed window
  assign store_ok = REQ.store && REQ.from_boot && arm_q != 3'h0 && // RL1 RL2 RL22
    GEN_LOCK == fspg_pkg::LK_NONE && // RL12 RL13
    !(tgt_boot ? boot_pair_st : app_pair_st) && // RL24
    state_q == fspg_pkg::FSPG_IDLE;
  // loads: cross-section lock by source section, rww invalid when busy
  assign load_ok = REQ.load && GEN_LOCK != fspg_pkg::LK_RW && // RL13
    !(tgt_boot && !REQ.from_boot && boot_pair_ld) && // RL20 RL24
    !(!tgt_boot && REQ.from_boot && app_pair_ld); // RL16

  // control register and arm window after a command write; the enable
  // bit stands through the whole operation so the irq waits for its end
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      ctrl_q <= 8'h00;
      arm_q <= 3'h0;
    end
    else if (REG_WR && REG_ADDR == fspg_pkg::REG_CTRL)
    begin
      ctrl_q <= REG_WDATA;
      arm_q <= 3'(fspg_pkg::ARM_CYC);
    end
    else if (store_ok)
    begin
      arm_q <= 3'h0; // one store per command write
      if (!prog_cmd)
      begin
        ctrl_q[fspg_pkg::CTRL_SPE] <= 1'b0; // page load ends at once
      end
    end
    else if (state_q != fspg_pkg::FSPG_IDLE)
    begin
      if (cnt_q == CW'(1))
      begin
        ctrl_q[fspg_pkg::CTRL_SPE] <= 1'b0; // enable drops when the op ends
      end
    end
    else if (arm_q != 3'h0)
    begin
      arm_q <= arm_q - 3'h1;
    end
    else
    begin
      ctrl_q[fspg_pkg::CTRL_SPE] <= 1'b0; // window lapsed
    end
  end

  // boot lock bits: software may only program (clear) them
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      blb_q <= fspg_pkg::BLB_RST;
    end
    else if (CHIP_ERASE)
    begin
      blb_q <= fspg_pkg::BLB_RST; // RL11
    end
    else if (REG_WR && REG_ADDR == fspg_pkg::REG_LOCK)
    begin
      blb_q <= blb_q & REG_WDATA[3:0]; // RL11
    end
  end

  // programming sequencer; rww page lets core run, no_read_while_write_region page halts it
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= fspg_pkg::FSPG_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        fspg_pkg::FSPG_IDLE:
        begin
          if (store_ok && prog_cmd)
          begin
            state_q <= tgt_rww ? fspg_pkg::FSPG_RWW : fspg_pkg::FSPG_NO_READ_WHILE_WRITE_REGION; // RL4 RL5
            cnt_q <= CW'(PROG_CYCLES);
          end
        end
        default:
        begin
          if (cnt_q == CW'(1))
          begin
            state_q <= fspg_pkg::FSPG_IDLE;
          end
          cnt_q <= cnt_q - CW'(1);
        end
      endcase
    end
  end

  // busy flag: set wins over the software clear
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      rww_busy_flag_q <= 1'b0;
    end
    else if (store_ok && prog_cmd && tgt_rww)
    begin
      rww_busy_flag_q <= 1'b1; // RL25 RL8
    end
    else if (REG_WR && REG_ADDR == fspg_pkg::REG_CTRL && REG_WDATA[fspg_pkg::CTRL_RWWCLR]
      && state_q == fspg_pkg::FSPG_IDLE)
    begin
      rww_busy_flag_q <= 1'b0; // RL9
    end
  end

  // registered outputs toward the core
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      CORE_HALT <= 1'b0;
      LOAD_GRANT <= 1'b0;
      LOAD_VALID <= 1'b0;
      PROG_START <= 1'b0;
      PROG_BUSY <= 1'b0;
      INT_BLOCK <= 1'b0;
      SPM_IRQ <= 1'b0;
    end
    else
    begin
      CORE_HALT <= (store_ok && prog_cmd && !tgt_rww) ||
        (state_q == fspg_pkg::FSPG_NO_READ_WHILE_WRITE_REGION && cnt_q != CW'(1)); // RL5
      LOAD_GRANT <= load_ok; // RL24
      // rww data is not valid while busy; no_read_while_write_region still served
      LOAD_VALID <= load_ok && !(tgt_rww && rww_busy_flag_q); // RL6 RL4
      PROG_START <= store_ok && prog_cmd; // RL2
      PROG_BUSY <= state_q != fspg_pkg::FSPG_IDLE;
      INT_BLOCK <= (!REQ.from_boot && IVEC_IN_BOOT && app_pair_ld) || // RL17
        (REQ.from_boot && !IVEC_IN_BOOT && boot_pair_ld); // RL21
      SPM_IRQ <= ctrl_q[fspg_pkg::CTRL_IE] && !ctrl_q[fspg_pkg::CTRL_SPE]; // RL23
    end
  end

  // register reads, data one cycle later
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      REG_RDATA <= 8'h00;
    end
    else if (REG_RD)
    begin
      if (REG_ADDR == fspg_pkg::REG_CTRL)
      begin
        REG_RDATA <= {ctrl_q[7], rww_busy_flag_q, ctrl_q[5:0]}; // RL8
      end
      else if (REG_ADDR == fspg_pkg::REG_STAT)
      begin
        REG_RDATA <= {5'h00, state_q, rww_busy_flag_q};
      end
      else if (REG_ADDR == fspg_pkg::REG_LOCK)
      begin
        REG_RDATA <= {4'h0, blb_q};
      end
      else
      begin
        REG_RDATA <= 8'h00; // unmapped reads zero
      end
    end
    else
    begin
      REG_RDATA <= 8'h00;
    end
  end

  sequence s_start_rww;
    store_ok && prog_cmd && tgt_rww;
  endsequence


  sequence s_start_no_read_while_write_region;
    store_ok && prog_cmd && !tgt_rww;
  endsequence

  // software clear of the busy flag through the control register
  sequence s_busy_clear;
    REG_WR && REG_ADDR == fspg_pkg::REG_CTRL && REG_WDATA[fspg_pkg::CTRL_RWWCLR];
  endsequence

  a_app_store_drop: assert property (@(posedge CORE_CLK) disable iff (RST) // RL1
    REQ.store && !REQ.from_boot |=> !PROG_START)
    else $error("store from application started programming");
  a_busy_set: assert property (@(posedge CORE_CLK) disable iff (RST) // RL25
    s_start_rww |=> rww_busy_flag_q)
    else $error("busy flag not set on rww programming");
  a_no_read_while_write_region_halt: assert property (@(posedge CORE_CLK) disable iff (RST) // RL5
    state_q == fspg_pkg::FSPG_NO_READ_WHILE_WRITE_REGION && cnt_q > CW'(1) |=> CORE_HALT)
    else $error("core not halted during no_read_while_write_region programming");
  a_rww_no_halt: assert property (@(posedge CORE_CLK) disable iff (RST) // RL4
    state_q == fspg_pkg::FSPG_RWW |=> !CORE_HALT)
    else $error("core halted during rww programming");
  a_wlock_store: assert property (@(posedge CORE_CLK) disable iff (RST) // RL12
    GEN_LOCK != fspg_pkg::LK_NONE && REQ.store |=> !PROG_START)
    else $error("store accepted under write lock");
  a_rwlock_load: assert property (@(posedge CORE_CLK) disable iff (RST) // RL13
    GEN_LOCK == fspg_pkg::LK_RW && REQ.load |=> !LOAD_GRANT)
    else $error("load granted under read/write lock");
  a_busy_load_inv: assert property (@(posedge CORE_CLK) disable iff (RST) // RL6
    rww_busy_flag_q && REQ.load && tgt_rww |=> !LOAD_VALID)
    else $error("rww load valid while busy");
  a_boot_in_no_read_while_write_region: assert property (@(posedge CORE_CLK) disable iff (RST) // RL7
    boot_start >= AW'(NO_READ_WHILE_WRITE_REGION_START))
    else $error("boot section outside no_read_while_write_region region");
  a_irq_level: assert property (@(posedge CORE_CLK) disable iff (RST) // RL23
    ctrl_q[fspg_pkg::CTRL_IE] && !ctrl_q[fspg_pkg::CTRL_SPE] |=> SPM_IRQ)
    else $error("interrupt not held while enable clear");
  a_lock_sticky: assert property (@(posedge CORE_CLK) disable iff (RST) // RL11
    !CHIP_ERASE |=> (blb_q & ~$past(blb_q)) == 4'h0)
    else $error("lock bit returned to unprogrammed without erase");

  // section locks refuse stores and loads silently
  a_app_store_lock: assert property (@(posedge CORE_CLK) disable iff (RST) // RL15
    REQ.store && !tgt_boot && !blb_q[0] |=> !PROG_START)
    else $error("store into locked application section started");
  a_boot_store_lock: assert property (@(posedge CORE_CLK) disable iff (RST) // RL19
    REQ.store && tgt_boot && !blb_q[2] |=> !PROG_START)
    else $error("store into locked boot section started");
  a_app_load_lock: assert property (@(posedge CORE_CLK) disable iff (RST) // RL16
    REQ.load && REQ.from_boot && !tgt_boot && !blb_q[1] |=> !LOAD_GRANT)
    else $error("boot load from locked application section granted");
  a_boot_load_lock: assert property (@(posedge CORE_CLK) disable iff (RST) // RL20
    REQ.load && !REQ.from_boot && tgt_boot && !blb_q[3] |=> !LOAD_GRANT)
    else $error("application load from locked boot section granted");
  a_free_load: assert property (@(posedge CORE_CLK) disable iff (RST) // RL14
    REQ.load && GEN_LOCK != fspg_pkg::LK_RW && blb_q == 4'hf |=> LOAD_GRANT)
    else $error("load refused with all locks open");

  // a clean boot store under no lock always starts
  a_boot_store_start: assert property (@(posedge CORE_CLK) disable iff (RST) // RL2
    REQ.store && REQ.from_boot && arm_q != 3'h0 && prog_cmd && blb_q == 4'hf &&
    GEN_LOCK == fspg_pkg::LK_NONE && state_q == fspg_pkg::FSPG_IDLE |=> PROG_START)
    else $error("clean boot store did not start programming");

  // interrupt masking by lock mode and vector place
  a_app_int_mask: assert property (@(posedge CORE_CLK) disable iff (RST) // RL17
    !REQ.from_boot && IVEC_IN_BOOT && !blb_q[1] |=> INT_BLOCK)
    else $error("interrupts not masked in application section");
  a_boot_int_mask: assert property (@(posedge CORE_CLK) disable iff (RST) // RL21
    REQ.from_boot && !IVEC_IN_BOOT && !blb_q[3] |=> INT_BLOCK)
    else $error("interrupts not masked in boot section");

  // status reads show the busy flag; irq quiet while enabled
  a_stat_busy_read: assert property (@(posedge CORE_CLK) disable iff (RST) // RL8
    REG_RD && REG_ADDR == fspg_pkg::REG_STAT |=> REG_RDATA[0] == $past(rww_busy_flag_q))
    else $error("status read does not show busy flag");
  a_ctrl_busy_read: assert property (@(posedge CORE_CLK) disable iff (RST) // RL8
    REG_RD && REG_ADDR == fspg_pkg::REG_CTRL |=> REG_RDATA[6] == $past(rww_busy_flag_q))
    else $error("control read does not show busy flag");
  a_irq_quiet: assert property (@(posedge CORE_CLK) disable iff (RST) // RL23
    ctrl_q[fspg_pkg::CTRL_SPE] |=> !SPM_IRQ)
    else $error("interrupt raised while enable set");

  // busy flag holds until a clear, clear works when idle
  a_busy_hold: assert property (@(posedge CORE_CLK) disable iff (RST) // RL25
    rww_busy_flag_q && !(REG_WR && REG_ADDR == fspg_pkg::REG_CTRL &&
    REG_WDATA[fspg_pkg::CTRL_RWWCLR]) |=> rww_busy_flag_q)
    else $error("busy flag dropped without a clear");
  a_busy_clear: assert property (@(posedge CORE_CLK) disable iff (RST) // RL25
    s_busy_clear ##0 (state_q == fspg_pkg::FSPG_IDLE && !(store_ok && prog_cmd && tgt_rww))
    |=> !rww_busy_flag_q)
    else $error("busy flag not cleared by software");

  // program starts: no_read_while_write_region halts at once, rww keeps the core running
  a_no_read_while_write_region_halt_start: assert property (@(posedge CORE_CLK) disable iff (RST) // RL5
    s_start_no_read_while_write_region |=> CORE_HALT ##1 PROG_BUSY)
    else $error("no_read_while_write_region start did not halt the core");
  a_rww_start_run: assert property (@(posedge CORE_CLK) disable iff (RST) // RL4
    s_start_rww |=> PROG_START && !CORE_HALT)
    else $error("rww start halted the core");
endmodule

// *** tb/fspg_core_model.sv ***
/*
  fspg_core_model: processor core stand-in issuing program-memory requests.
  assumes: the guard samples REQ on the rising clock edge.
*/
`timescale 1ns/10ps
module fspg_core_model (
  input wire logic clk,
  output fspg_pkg::fspg_req_t req
);
  initial req = '0;
  // one pulse after an idle gap; a long gap steps past the arm window
  task automatic issue(input logic st, input logic ld,
    input logic [fspg_pkg::ADDR_W-1:0] a, input logic boot, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req <= '{store: st, load: ld, addr: a, from_boot: boot};
    @(posedge clk);
    req.store <= 1'b0;
    req.load <= 1'b0;
    req.addr <= ~a; // released address is not held
  endtask
endmodule

// *** tb/tb.sv ***
/*
  tb: self-checking bench for the flash self-program guard.
  assumes: core model drives REQ; bench drives fuses, locks and registers.
*/
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  fspg_pkg::fspg_req_t req;
  logic [1:0] fuse = 2'h3;
  logic [1:0] gen_lock = fspg_pkg::LK_NONE;
  logic ivec = 1'b0;
  logic erase = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic halt, grant, valid, start, busy, int_block, irq;
  logic [1:0] modes [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
  logic [7:0] d;
  logic s;
  int fails = 0;
  int checks_done = 0;

  always #4 core_clk = ~core_clk;

  fspg_guard #(.PROG_CYCLES(20), .NO_READ_WHILE_WRITE_REGION_START(14'h3800)) i_dut (
    .CORE_CLK(core_clk), .RST(rst), .REQ(req), .BOOT_SIZE_FUSES(fuse),
    .GEN_LOCK(gen_lock), .IVEC_IN_BOOT(ivec), .CHIP_ERASE(erase),
    .REG_ADDR(ra), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .CORE_HALT(halt), .LOAD_GRANT(grant), .LOAD_VALID(valid), .PROG_START(start),
    .PROG_BUSY(busy), .INT_BLOCK(int_block), .SPM_IRQ(irq));

  fspg_core_model i_core (.clk(core_clk), .req(req));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] f);
    @(posedge core_clk);
    rst <= 1'b1;
    fuse <= f;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    ra <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    v = rdata;
  endtask

  task automatic chip_erase;
    @(posedge core_clk);
    erase <= 1'b1;
    @(posedge core_clk);
    erase <= 1'b0;
  endtask

  task automatic wait_idle;
    for (int n = 0; n < 40 && busy === 1'b1; n++)
      @(negedge core_clk);
    chk("prog_busy end", 1'b0, busy);
  endtask

  task automatic ld(input logic [13:0] a, input logic boot, input logic g, input logic v);
    i_core.issue(1'b0, 1'b1, a, boot, 0);
    @(negedge core_clk);
    chk("load_grant", g, grant);
    chk("load_valid", v, valid);
  endtask

  // arm, store, then judge start, halt and the busy flag lifecycle
  task automatic prog(input logic [13:0] a, input logic boot, input int gap, input logic ok);
    logic read_while_write_region;
    read_while_write_region = a < 14'h3800;
    bus_write(fspg_pkg::REG_CTRL, fspg_pkg::CMD_WRITE);
    i_core.issue(1'b1, 1'b0, a, boot, gap);
    @(negedge core_clk);
    chk("prog_start", ok, start);
    chk("core_halt", ok && !read_while_write_region, halt);
    // busy output follows the sequencer state one cycle behind
    @(negedge core_clk);
    chk("prog_busy", ok, busy);
    if (ok)
    begin
      bus_read(fspg_pkg::REG_STAT, d);
      chk("busy flag set", read_while_write_region, d[0]);
      bus_read(fspg_pkg::REG_CTRL, d);
      chk("ctrl busy bit", read_while_write_region, d[6]);
      wait_idle;
      if (read_while_write_region)
      begin
        bus_read(fspg_pkg::REG_STAT, d);
        chk("busy flag held", 1'b1, d[0]);
        bus_write(fspg_pkg::REG_CTRL, 8'h10);
        bus_read(fspg_pkg::REG_STAT, d);
        chk("busy flag cleared", 1'b0, d[0]);
      end
    end
  endtask

  initial
  begin
    #(fspg_pkg::CLK_NS * 20000);
    fails++;
    end_of_test;
  end

  initial
  begin
    do_reset(2'h3);
    @(negedge core_clk);
    chk("halt after reset", 1'b0, halt);
    bus_read(fspg_pkg::REG_LOCK, d);
    chk("lock reset", 8'h0f, d);
    bus_read(4'hf, d);
    chk("unmapped read", 8'h00, d);
    prog(14'h0100, 1'b0, 0, 1'b0);
    prog(14'h0100, 1'b1, 2, 1'b1);
    prog(14'h0100, 1'b1, 3, 1'b0);
    prog(14'h3f00, 1'b1, 0, 1'b1);
    // loads during and after a rww page program, irq enable set until the busy clear write
    bus_write(fspg_pkg::REG_CTRL, 8'h85);
    i_core.issue(1'b1, 1'b0, 14'h0100, 1'b1, 0);
    ld(14'h3900, 1'b1, 1'b1, 1'b1);
    ld(14'h0100, 1'b1, 1'b1, 1'b0);
    chk("irq while busy", 1'b0, irq);
    wait_idle;
    ld(14'h0100, 1'b1, 1'b1, 1'b0);
    chk("irq when idle", 1'b1, irq);
    bus_write(fspg_pkg::REG_CTRL, 8'h10);
    ld(14'h0100, 1'b1, 1'b1, 1'b1);
    chk("irq disabled", 1'b0, irq);
    // lock bits only move towards programmed until a chip erase
    bus_write(fspg_pkg::REG_LOCK, 8'h0e);
    bus_write(fspg_pkg::REG_LOCK, 8'h0f);
    bus_read(fspg_pkg::REG_LOCK, d);
    chk("lock write-and", 8'h0e, d);
    chip_erase;
    bus_read(fspg_pkg::REG_LOCK, d);
    chk("lock after erase", 8'h0f, d);
    // every mode of each pair, section s locked, the other left free
    for (int si = 0; si < 2; si++)
      for (int i = 0; i < 4; i++)
      begin
        s = si[0];
        chip_erase;
        bus_write(fspg_pkg::REG_LOCK, s ? {4'h0, modes[i], 2'h3} : {4'h0, 2'h3, modes[i]});
        @(posedge core_clk);
        ivec <= ~s;
        prog(s ? 14'h3f00 : 14'h0100, 1'b1, 0, modes[i][0]);
        ld(s ? 14'h3f00 : 14'h0100, ~s, modes[i][1], modes[i][1]);
        i_core.issue(1'b0, 1'b0, 14'h0000, s, 0);
        @(negedge core_clk);
        chk("int_block", !modes[i][1], int_block);
      end
    chip_erase;
    @(posedge core_clk);
    gen_lock <= fspg_pkg::LK_WRITE;
    prog(14'h0100, 1'b1, 0, 1'b0);
    ld(14'h0100, 1'b1, 1'b1, 1'b1);
    @(posedge core_clk);
    gen_lock <= fspg_pkg::LK_RW;
    ld(14'h0100, 1'b1, 1'b0, 1'b0);
    prog(14'h0100, 1'b1, 0, 1'b0);
    @(posedge core_clk);
    gen_lock <= fspg_pkg::LK_NONE;
    // section boundary follows the fuses, boot kept inside no_read_while_write_region
    bus_write(fspg_pkg::REG_LOCK, 8'h0b);
    prog(14'h3d00, 1'b1, 0, 1'b1);
    do_reset(2'h0);
    bus_write(fspg_pkg::REG_LOCK, 8'h0b);
    prog(14'h3d00, 1'b1, 0, 1'b0);
    prog(14'h3700, 1'b1, 0, 1'b1);
    end_of_test;
  end
endmodule
